/* File: include/status_pkg.sv */
// shared constants, command codes and helpers of the status reporting block
package status_pkg;

  // -------------------------------------------------------------------------
  // widths and error queue depth
  // -------------------------------------------------------------------------
  localparam int STAT_W = 16;
  localparam int STB_W = 8;
  localparam int ERR_DEPTH_DEF = 4;

  // -------------------------------------------------------------------------
  // command code: [4:3] selects the group, [2:0] the action
  // -------------------------------------------------------------------------
  localparam logic [1:0] GRP_QUES = 2'h0;
  localparam logic [1:0] GRP_OPER = 2'h1;
  localparam logic [1:0] GRP_SEC = 2'h2;
  localparam logic [1:0] GRP_MISC = 2'h3;

  localparam logic [2:0] SUB_CONDITION_SNAPSHOT = 3'h0;
  localparam logic [2:0] SUB_EVENT = 3'h1;
  localparam logic [2:0] SUB_PLAIN = 3'h2;
  localparam logic [2:0] SUB_ENAB_WR = 3'h3;
  localparam logic [2:0] SUB_ENAB_RD = 3'h4;

  localparam logic [2:0] SUB_STB = 3'h0;
  localparam logic [2:0] SUB_CLS = 3'h1;
  localparam logic [2:0] SUB_ERR = 3'h2;
  localparam logic [2:0] SUB_RST = 3'h3;

  // -------------------------------------------------------------------------
  // bit positions
  // -------------------------------------------------------------------------
  localparam int QUES_OVERVOLTAGE_BIT = 0;
  localparam int QUES_OVERTEMP_BIT = 1;
  localparam int QUES_REMOTE_BIT = 10;
  localparam int QUES_DC_ON_BIT = 11;
  localparam int QUES_POWER_FAIL_BIT = 13;
  localparam int OPER_CV_BIT = 8;
  localparam int OPER_CC_BIT = 9;
  localparam int OPER_CP_BIT = 10;
  localparam int OPER_AUX_BIT = 11;
  localparam int STB_ERR_BIT = 2;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_OPER_BIT = 7;

  // -------------------------------------------------------------------------
  // reset values, limits and implemented bits
  // -------------------------------------------------------------------------
  localparam logic [STAT_W-1:0] QUES_ENAB_RST = 16'h7fff;
  localparam logic [STAT_W-1:0] QUES_ENAB_MAX = 16'h7fff;
  localparam logic [STAT_W-1:0] SEC_ENAB_RST = 16'h7fff;
  localparam logic [STAT_W-1:0] OPER_ENAB_RST = 16'h0f00;
  localparam logic [STAT_W-1:0] OPER_ENAB_MIN = 16'h0100;
  localparam logic [STAT_W-1:0] OPER_ENAB_MAX = 16'h0f00;
  localparam logic [STAT_W-1:0] QUES_IMPL = 16'h2c03;
  localparam logic [STAT_W-1:0] QUES_ALARM = 16'h2003;
  localparam logic [STAT_W-1:0] OPER_IMPL = 16'h0f00;
  localparam logic [STAT_W-1:0] OPER_ALARM = 16'h0000;
  localparam logic [STAT_W-1:0] SEC_IMPL = 16'h7fff;
  localparam logic [STAT_W-1:0] SEC_ALARM = 16'h7fff;

  // error codes, 16-bit two's complement
  localparam logic [STAT_W-1:0] ERR_NONE = 16'h0000;
  localparam logic [STAT_W-1:0] ERR_SAFETY_OVP = 16'hfc19;

  // accepted enable values per group
  function automatic logic enab_ok(input logic [1:0] grp, input logic [STAT_W-1:0] v);
    if (grp == GRP_OPER) begin
      enab_ok = (v == '0) || ((v >= OPER_ENAB_MIN) && (v <= OPER_ENAB_MAX));
    end else begin
      enab_ok = (v <= QUES_ENAB_MAX);
    end
  endfunction : enab_ok

endpackage : status_pkg

/* File: core/status_group.sv */
// one status group: condition snapshot, rising-edge event latch, enable mask
`timescale 1ns/1ns
module status_group import status_pkg::*; #(
  parameter logic [STAT_W-1:0] IMPL = 16'hffff,
  parameter logic [STAT_W-1:0] ALARM = 16'h0000,
  parameter logic [STAT_W-1:0] ENAB_RST = 16'hffff,
  parameter bit MASK_BEFORE = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [STAT_W-1:0] raw_i,
  input wire logic ack_i,
  input wire logic clr_i,
  input wire logic enab_we_i,
  input wire logic [STAT_W-1:0] enab_wdata_i,
  output logic [STAT_W-1:0] condition_snapshot_o,
  output logic [STAT_W-1:0] event_o,
  output logic [STAT_W-1:0] enab_o,
  output logic summary_o
);

  typedef struct packed {
    logic [STAT_W-1:0] enab;
    logic [STAT_W-1:0] evt;
    logic [STAT_W-1:0] latch;
    logic [STAT_W-1:0] prev;
  } group_state_t;

  group_state_t s_ff;
  group_state_t nxt_s;
  logic [STAT_W-1:0] live;
  logic [STAT_W-1:0] filt;
  logic [STAT_W-1:0] rise;

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  // alarms stay latched until acknowledged and gone; others follow live
  always_comb begin
    live = ((raw_i & ~ALARM) | s_ff.latch) & IMPL;
    filt = MASK_BEFORE ? (live & s_ff.enab) : live;
    rise = filt & ~s_ff.prev;
    nxt_s = s_ff;
    nxt_s.latch = (raw_i & ALARM & IMPL) | (ack_i ? '0 : s_ff.latch);
    nxt_s.prev = filt;
    nxt_s.evt = ((clr_i ? '0 : s_ff.evt) | rise) & IMPL;
    if (enab_we_i) begin
      nxt_s.enab = enab_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_ff <= '{enab: ENAB_RST, evt: '0, latch: '0, prev: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign condition_snapshot_o = live;
  assign event_o = s_ff.evt;
  assign enab_o = s_ff.enab;
  assign summary_o = |(s_ff.evt & s_ff.enab);

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  a_event_rise_only: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ##1 ((event_o & ~$past(event_o) & ~($past(filt) & ~$past(s_ff.prev))) == '0))
    else $error("event bit set without a rising condition");

  a_clear_drops: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (clr_i && (rise == '0)) |=> ((event_o == '0) && !summary_o))
    else $error("event read did not clear the latch");

  a_alarm_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !ack_i |=> ((condition_snapshot_o & $past(condition_snapshot_o) & ALARM) == ($past(condition_snapshot_o) & ALARM)))
    else $error("alarm dropped from condition before acknowledge");

  a_ack_persist: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ack_i |=> ((condition_snapshot_o & $past(raw_i) & ALARM & IMPL) == ($past(raw_i) & ALARM & IMPL)))
    else $error("acknowledge cleared an alarm whose cause persists");

  a_ack_release: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (ack_i && ((raw_i & ALARM) == '0)) ##1 ((raw_i & ALARM) == '0) |-> ((condition_snapshot_o & ALARM) == '0))
    else $error("acknowledged alarm without cause still shown");

  a_unimpl_quiet: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ((condition_snapshot_o | event_o) & ~IMPL) == '0)
    else $error("unimplemented status bit active");

endmodule : status_group

/* File: core/error_queue.sv */
// error queue with a sticky entry that only reset removes
`timescale 1ns/1ns
module error_queue import status_pkg::*; #(
  parameter int DEPTH = ERR_DEPTH_DEF
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic push_i,
  input wire logic [STAT_W-1:0] code_i,
  input wire logic pop_i,
  input wire logic flush_i,
  input wire logic sticky_i,
  output logic [STAT_W-1:0] head_o,
  output logic pending_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][STAT_W-1:0] mem;
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [CW-1:0] cnt;
  } queue_state_t;

  queue_state_t s_ff;
  queue_state_t nxt_s;
  logic do_pop;
  logic do_push;

  // wrapping pointer step
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : step

  // -------------------------------------------------------------------------
  // next state; a push in the flush cycle survives, new errors drop when full unless a pop frees a slot in the same cycle
  // -------------------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    do_pop = pop_i && (s_ff.cnt != '0) && !flush_i;
    do_push = push_i && (flush_i || (s_ff.cnt != FULL) || do_pop);
    if (flush_i) begin
      nxt_s.rd = '0;
      nxt_s.wr = '0;
      nxt_s.cnt = '0;
    end
    if (do_pop) begin
      nxt_s.rd = step(s_ff.rd);
      nxt_s.cnt = nxt_s.cnt - 1'b1;
    end
    if (do_push) begin
      nxt_s.mem[nxt_s.wr] = code_i;
      nxt_s.wr = step(nxt_s.wr);
      nxt_s.cnt = nxt_s.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // sticky entry is reported once the ordinary entries are drained
  assign head_o = (s_ff.cnt != '0) ? s_ff.mem[s_ff.rd] :
                  (sticky_i ? ERR_SAFETY_OVP : ERR_NONE);
  assign pending_o = (s_ff.cnt != '0) || sticky_i;

endmodule : error_queue

/* File: core/status_event_reporting.sv */
// status byte, three status groups, alarm acknowledge and safety overvoltage
`timescale 1ns/1ns
module status_event_reporting import status_pkg::*; #(
  parameter int ERR_DEPTH = ERR_DEPTH_DEF,
  parameter logic [STAT_W-1:0] SEC_IMPL_BITS = SEC_IMPL,
  parameter logic [STAT_W-1:0] SEC_ALARM_BITS = SEC_ALARM
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic cmd_valid_i,
  input wire logic [4:0] cmd_code_i,
  input wire logic [STAT_W-1:0] cmd_data_i,
  output logic rsp_valid_o,
  output logic [STAT_W-1:0] rsp_data_o,
  output logic rsp_error_o,
  output logic [STB_W-1:0] status_byte_o,
  input wire logic overvoltage_alarm_i,
  input wire logic overtemperature_alarm_i,
  input wire logic power_fail_alarm_i,
  input wire logic safety_overvoltage_alarm_i,
  input wire logic remote_active_i,
  input wire logic dc_on_i,
  input wire logic constant_voltage_state_i,
  input wire logic constant_current_state_i,
  input wire logic constant_power_state_i,
  input wire logic regulation_aux_i,
  input wire logic [STAT_W-1:0] sec_ques_raw_i,
  input wire logic err_push_i,
  input wire logic [STAT_W-1:0] err_code_i
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  localparam int RAW_W = 10 + STAT_W;

  typedef struct packed {
    logic [RAW_W-1:0] sync1;
    logic [RAW_W-1:0] sync2;
    logic [RAW_W-1:0] sync3;
    logic [RAW_W-1:0] clean;
    logic safety_overvoltage_alarm;
    logic rsp_valid;
    logic [STAT_W-1:0] rsp_data;
    logic rsp_error;
    logic [STB_W-1:0] stb;
  } main_state_t;

  main_state_t s_ff;
  main_state_t nxt_s;
  logic [RAW_W-1:0] pins;
  logic [STAT_W-1:0] ques_raw;
  logic [STAT_W-1:0] oper_raw;
  logic [STAT_W-1:0] sec_raw;
  logic [1:0] grp;
  logic [2:0] sub;
  logic is_misc;
  logic clr_all;
  logic alarm_ack;
  logic err_query;
  logic enab_wr;
  logic enab_good;
  logic ques_clr;
  logic oper_clr;
  logic sec_clr;
  logic ques_we;
  logic oper_we;
  logic sec_we;
  logic [STAT_W-1:0] ques_condition_snapshot;
  logic [STAT_W-1:0] ques_event;
  logic [STAT_W-1:0] ques_enab;
  logic [STAT_W-1:0] oper_condition_snapshot;
  logic [STAT_W-1:0] oper_event;
  logic [STAT_W-1:0] oper_enab;
  logic [STAT_W-1:0] sec_condition_snapshot;
  logic [STAT_W-1:0] sec_event;
  logic [STAT_W-1:0] sec_enab;
  logic ques_sum;
  logic oper_sum;
  logic sec_sum;
  logic [STAT_W-1:0] err_head;
  logic err_pending;

  // -------------------------------------------------------------------------
  // pin inputs and raw status words
  // -------------------------------------------------------------------------
  assign pins = {sec_ques_raw_i, regulation_aux_i, constant_power_state_i,
                 constant_current_state_i, constant_voltage_state_i, dc_on_i,
                 remote_active_i, safety_overvoltage_alarm_i, power_fail_alarm_i,
                 overtemperature_alarm_i, overvoltage_alarm_i};

  // safety overvoltage shows only as power fail plus overvoltage
  always_comb begin
    ques_raw = '0;
    ques_raw[QUES_OVERVOLTAGE_BIT] = s_ff.clean[0] | s_ff.safety_overvoltage_alarm;
    ques_raw[QUES_OVERTEMP_BIT] = s_ff.clean[1];
    ques_raw[QUES_POWER_FAIL_BIT] = s_ff.clean[2] | s_ff.safety_overvoltage_alarm;
    ques_raw[QUES_REMOTE_BIT] = s_ff.clean[4];
    ques_raw[QUES_DC_ON_BIT] = s_ff.clean[5];
    oper_raw = '0;
    oper_raw[OPER_CV_BIT] = s_ff.clean[6];
    oper_raw[OPER_CC_BIT] = s_ff.clean[7];
    oper_raw[OPER_CP_BIT] = s_ff.clean[8];
    oper_raw[OPER_AUX_BIT] = s_ff.clean[9];
    sec_raw = s_ff.clean[RAW_W-1:10];
  end

  // -------------------------------------------------------------------------
  // command decode
  // -------------------------------------------------------------------------
  assign grp = cmd_code_i[4:3];
  assign sub = cmd_code_i[2:0];
  assign is_misc = cmd_valid_i && (grp == GRP_MISC);
  assign clr_all = is_misc && ((sub == SUB_CLS) || (sub == SUB_RST));
  assign alarm_ack = is_misc && ((sub == SUB_ERR) || (sub == SUB_RST));
  assign err_query = is_misc && (sub == SUB_ERR);
  assign enab_wr = cmd_valid_i && !is_misc && (sub == SUB_ENAB_WR);
  assign enab_good = enab_ok(grp, cmd_data_i);

  // event reads clear the group they read
  assign ques_clr = clr_all || (cmd_valid_i && (grp == GRP_QUES) &&
                    ((sub == SUB_EVENT) || (sub == SUB_PLAIN)));
  assign oper_clr = clr_all || (cmd_valid_i && (grp == GRP_OPER) &&
                    ((sub == SUB_EVENT) || (sub == SUB_PLAIN)));
  assign sec_clr = clr_all || (cmd_valid_i && (grp == GRP_SEC) &&
                   ((sub == SUB_EVENT) || (sub == SUB_PLAIN)));
  assign ques_we = enab_wr && enab_good && (grp == GRP_QUES);
  assign oper_we = enab_wr && enab_good && (grp == GRP_OPER);
  assign sec_we = enab_wr && enab_good && (grp == GRP_SEC);

  // -------------------------------------------------------------------------
  // status groups and error queue
  // -------------------------------------------------------------------------
  status_group #(.IMPL(QUES_IMPL), .ALARM(QUES_ALARM), .ENAB_RST(QUES_ENAB_RST),
                 .MASK_BEFORE(1'b0)) u_ques (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .raw_i(ques_raw),
    .ack_i(alarm_ack),
    .clr_i(ques_clr),
    .enab_we_i(ques_we),
    .enab_wdata_i(cmd_data_i),
    .condition_snapshot_o(ques_condition_snapshot),
    .event_o(ques_event),
    .enab_o(ques_enab),
    .summary_o(ques_sum)
  );

  // operation mask filters conditions ahead of the event latch
  status_group #(.IMPL(OPER_IMPL), .ALARM(OPER_ALARM), .ENAB_RST(OPER_ENAB_RST),
                 .MASK_BEFORE(1'b1)) u_oper (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .raw_i(oper_raw),
    .ack_i(alarm_ack),
    .clr_i(oper_clr),
    .enab_we_i(oper_we),
    .enab_wdata_i(cmd_data_i),
    .condition_snapshot_o(oper_condition_snapshot),
    .event_o(oper_event),
    .enab_o(oper_enab),
    .summary_o(oper_sum)
  );

  status_group #(.IMPL(SEC_IMPL_BITS), .ALARM(SEC_ALARM_BITS), .ENAB_RST(SEC_ENAB_RST),
                 .MASK_BEFORE(1'b0)) u_sec (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .raw_i(sec_raw),
    .ack_i(alarm_ack),
    .clr_i(sec_clr),
    .enab_we_i(sec_we),
    .enab_wdata_i(cmd_data_i),
    .condition_snapshot_o(sec_condition_snapshot),
    .event_o(sec_event),
    .enab_o(sec_enab),
    .summary_o(sec_sum)
  );

  error_queue #(.DEPTH(ERR_DEPTH)) u_errq (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .push_i(err_push_i),
    .code_i(err_code_i),
    .pop_i(err_query),
    .flush_i(is_misc && (sub == SUB_CLS)),
    .sticky_i(s_ff.safety_overvoltage_alarm),
    .head_o(err_head),
    .pending_o(err_pending)
  );

  // -------------------------------------------------------------------------
  // next state: synchroniser, safety latch, response and status byte
  // -------------------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.sync1 = pins;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.sync3 = s_ff.sync2;
    // a bit moves only where the last two stages agree
    nxt_s.clean = (s_ff.clean & (s_ff.sync2 ^ s_ff.sync3)) |
                  (s_ff.sync2 & ~(s_ff.sync2 ^ s_ff.sync3));
    nxt_s.safety_overvoltage_alarm = s_ff.safety_overvoltage_alarm | s_ff.clean[3];
    nxt_s.rsp_valid = cmd_valid_i;
    nxt_s.rsp_error = enab_wr && !enab_good;
    nxt_s.rsp_data = '0;
    if (cmd_valid_i) begin
      unique case (grp)
        GRP_QUES: begin
          unique case (sub)
            SUB_CONDITION_SNAPSHOT: nxt_s.rsp_data = ques_condition_snapshot;
            SUB_EVENT, SUB_PLAIN: nxt_s.rsp_data = ques_event;
            SUB_ENAB_RD: nxt_s.rsp_data = ques_enab;
            default: nxt_s.rsp_data = '0;
          endcase
        end
        GRP_OPER: begin
          unique case (sub)
            SUB_CONDITION_SNAPSHOT: nxt_s.rsp_data = oper_condition_snapshot;
            SUB_EVENT, SUB_PLAIN: nxt_s.rsp_data = oper_event;
            SUB_ENAB_RD: nxt_s.rsp_data = oper_enab;
            default: nxt_s.rsp_data = '0;
          endcase
        end
        GRP_SEC: begin
          unique case (sub)
            SUB_CONDITION_SNAPSHOT: nxt_s.rsp_data = sec_condition_snapshot;
            SUB_EVENT, SUB_PLAIN: nxt_s.rsp_data = sec_event;
            SUB_ENAB_RD: nxt_s.rsp_data = sec_enab;
            default: nxt_s.rsp_data = '0;
          endcase
        end
        GRP_MISC: begin
          unique case (sub)
            SUB_STB: nxt_s.rsp_data = {{(STAT_W-STB_W){1'b0}}, s_ff.stb};
            SUB_ERR: nxt_s.rsp_data = err_head;
            default: nxt_s.rsp_data = '0;
          endcase
        end
      endcase
    end
    nxt_s.stb = '0;
    nxt_s.stb[STB_ERR_BIT] = err_pending;
    nxt_s.stb[STB_QUES_BIT] = ques_sum | sec_sum;
    nxt_s.stb[STB_OPER_BIT] = oper_sum;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rsp_valid_o = s_ff.rsp_valid;
  assign rsp_data_o = s_ff.rsp_data;
  assign rsp_error_o = s_ff.rsp_error;
  assign status_byte_o = s_ff.stb;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  a_safety_overvoltage_alarm_bits: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    s_ff.safety_overvoltage_alarm |=> (ques_condition_snapshot[QUES_POWER_FAIL_BIT] && ques_condition_snapshot[QUES_OVERVOLTAGE_BIT]))
    else $error("safety overvoltage not shown as bits 13 and 0");

  a_safety_overvoltage_alarm_sticky: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    s_ff.safety_overvoltage_alarm |=> (s_ff.safety_overvoltage_alarm ##1 status_byte_o[STB_ERR_BIT]))
    else $error("safety overvoltage entry lost without reset");

  a_oper_reject: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (enab_wr && (grp == GRP_OPER) && !enab_good) |=> ($stable(oper_enab) && rsp_error_o))
    else $error("illegal operation mask accepted");

  a_plain_event: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (cmd_valid_i && (grp == GRP_QUES) && (sub == SUB_PLAIN)) |=>
    (rsp_valid_o && (rsp_data_o == $past(ques_event))))
    else $error("plain questionable query not answered with event word");

  a_stb_idle: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ((ques_event == '0) && (sec_event == '0) && (oper_event == '0) && !err_pending) |=>
    (status_byte_o == '0))
    else $error("status byte set with nothing recorded");

  a_cls_clears: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (is_misc && (sub == SUB_CLS) && !s_ff.safety_overvoltage_alarm && !err_push_i) |=> !err_pending)
    else $error("clear status left the error queue filled");

endmodule : status_event_reporting

/* File: tb/host_model.sv */
// host side model that issues status commands one at a time
`timescale 1ns/1ns
module host_model import status_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rsp_valid_i,
  input wire logic [STAT_W-1:0] rsp_data_i,
  input wire logic rsp_error_i,
  output logic cmd_valid_o,
  output logic [4:0] cmd_code_o,
  output logic [STAT_W-1:0] cmd_data_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = 5'h00;
    cmd_data_o = 16'h0000;
  end

  // one command pulse; the answer is taken one edge later as {valid, error, data}
  task automatic xfer(input logic [4:0] code, input logic [STAT_W-1:0] wdata,
                      output logic [17:0] rsp);
    @(posedge sys_clk_i);
    #2;
    cmd_valid_o = 1'b1;
    cmd_code_o = code;
    cmd_data_o = wdata;
    @(posedge sys_clk_i);
    #2;
    cmd_valid_o = 1'b0;
    cmd_data_o = ~wdata;
    rsp = {rsp_valid_i, rsp_error_i, rsp_data_i};
  endtask : xfer

  // alarm acknowledge: questionable status is read before the error query
  task automatic ack(output logic [17:0] rsp);
    xfer({GRP_QUES, SUB_PLAIN}, 16'h0000, rsp);
    xfer({GRP_MISC, SUB_ERR}, 16'h0000, rsp);
  endtask : ack
endmodule : host_model

/* File: tb/status_event_reporting_tb_top.sv */
// self-checking bench of the status reporting block
`timescale 1ns/1ns
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module status_event_reporting_tb_top import status_pkg::*; ;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [9:0] pins = 10'h000;
  logic [15:0] sec_raw = 16'h0000;
  logic err_push = 1'b0;
  logic [15:0] err_code = 16'h0000;
  logic cmd_valid, rsp_valid, rsp_error;
  logic [4:0] cmd_code;
  logic [15:0] cmd_data, rsp_data;
  logic [7:0] stb;
  logic [17:0] rsp;
  int mismatches = 0;
  int num_checks = 0;

  // ---------------------------------------------------------------------
  // clock, host model and design
  // ---------------------------------------------------------------------
  always #25 sys_clk_i = ~sys_clk_i;

  host_model host (.sys_clk_i(sys_clk_i), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data),
    .rsp_error_i(rsp_error), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
    .cmd_data_o(cmd_data));

  status_event_reporting dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_data_i(cmd_data),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_error_o(rsp_error),
    .status_byte_o(stb), .overvoltage_alarm_i(pins[0]), .overtemperature_alarm_i(pins[1]),
    .power_fail_alarm_i(pins[2]), .safety_overvoltage_alarm_i(pins[3]),
    .remote_active_i(pins[4]), .dc_on_i(pins[5]), .constant_voltage_state_i(pins[6]),
    .constant_current_state_i(pins[7]), .constant_power_state_i(pins[8]),
    .regulation_aux_i(pins[9]), .sec_ques_raw_i(sec_raw), .err_push_i(err_push),
    .err_code_i(err_code));

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [17:0] rd(input logic [15:0] d);
    rd = {2'b10, d};
  endfunction : rd

  task automatic do_cmd(input logic [4:0] code, input logic [15:0] wd, input logic [17:0] exp);
    host.xfer(code, wd, rsp);
    `CHK(rsp, exp)
  endtask : do_cmd

  // input sync, condition, event and status byte stages
  task automatic settle();
    repeat (6) @(posedge sys_clk_i);
    #2;
  endtask : settle

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk_i);
    #2;
    srst_i = 1'b0;
    do_cmd({GRP_QUES, SUB_ENAB_RD}, 16'h0, rd(16'h7fff));
    do_cmd({GRP_OPER, SUB_ENAB_RD}, 16'h0, rd(16'h0f00));
    `CHK(stb, 8'h00)
    $display("test reset done");
    pins[5:4] = 2'b11;
    sec_raw = 16'h0008;
    settle();
    `CHK(stb, 8'h08)
    do_cmd({GRP_QUES, SUB_PLAIN}, 16'h0, rd(16'h0c00));
    do_cmd({GRP_QUES, SUB_EVENT}, 16'h0, rd(16'h0000));
    do_cmd({GRP_QUES, SUB_CONDITION_SNAPSHOT}, 16'h0, rd(16'h0c00));
    do_cmd({GRP_SEC, SUB_EVENT}, 16'h0, rd(16'h0008));
    @(posedge sys_clk_i);
    #2;
    `CHK(stb, 8'h00)
    $display("test questionable done");
    do_cmd({GRP_QUES, SUB_ENAB_WR}, 16'h8000, 18'h30000);
    do_cmd({GRP_OPER, SUB_ENAB_WR}, 16'h00ff, 18'h30000);
    do_cmd({GRP_OPER, SUB_ENAB_WR}, 16'h0700, rd(16'h0));
    pins[9:6] = 4'b1001;
    settle();
    `CHK(stb, 8'h80)
    do_cmd({GRP_OPER, SUB_PLAIN}, 16'h0, rd(16'h0100));
    do_cmd({GRP_OPER, SUB_CONDITION_SNAPSHOT}, 16'h0, rd(16'h0900));
    $display("test operation done");
    pins[0] = 1'b1;
    settle();
    host.ack(rsp);
    `CHK(rsp, rd(16'h0000))
    do_cmd({GRP_QUES, SUB_CONDITION_SNAPSHOT}, 16'h0, rd(16'h0c01));
    pins[0] = 1'b0;
    settle();
    do_cmd({GRP_QUES, SUB_CONDITION_SNAPSHOT}, 16'h0, rd(16'h0c01));
    host.ack(rsp);
    do_cmd({GRP_QUES, SUB_CONDITION_SNAPSHOT}, 16'h0, rd(16'h0c00));
    do_cmd({GRP_QUES, SUB_EVENT}, 16'h0, rd(16'h0000));
    $display("test alarm done");
    err_code = 16'hff9c;
    err_push = 1'b1;
    @(posedge sys_clk_i);
    #2;
    err_push = 1'b0;
    settle();
    `CHK(stb[2], 1'b1)
    do_cmd({GRP_MISC, SUB_CLS}, 16'h0, rd(16'h0));
    @(posedge sys_clk_i);
    #2;
    `CHK(stb, 8'h00)
    pins[3] = 1'b1;
    settle();
    do_cmd({GRP_QUES, SUB_CONDITION_SNAPSHOT}, 16'h0, rd(16'h2c01));
    host.ack(rsp);
    `CHK(rsp, rd(16'hfc19))
    pins[3] = 1'b0;
    do_cmd({GRP_MISC, SUB_CLS}, 16'h0, rd(16'h0));
    settle();
    `CHK(stb[2], 1'b1)
    pins[1] = 1'b1;
    settle();
    pins[1] = 1'b0;
    settle();
    `CHK(stb, 8'h0c)
    do_cmd({GRP_MISC, SUB_RST}, 16'h0, rd(16'h0));
    do_cmd({GRP_QUES, SUB_CONDITION_SNAPSHOT}, 16'h0, rd(16'h2c01));
    do_cmd({GRP_MISC, SUB_STB}, 16'h0, rd(16'h0004));
    do_cmd({GRP_MISC, SUB_ERR}, 16'h0, rd(16'hfc19));
    $display("test safety done");
    srst_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #2;
    srst_i = 1'b0;
    `CHK(stb, 8'h00)
    do_cmd({GRP_OPER, SUB_ENAB_RD}, 16'h0, rd(16'h0f00));
    settle();
    `CHK(stb, 8'h88)
    do_cmd({GRP_MISC, SUB_ERR}, 16'h0, rd(16'h0000));
    $display("test second reset done");
    complete_run();
  end
endmodule : status_event_reporting_tb_top
